// ---- core/i2c_target_map.svh ----
// Constants for the I2C target front end: address, timing, capability.
// Included by the main module and the bench; definitions only.
`ifndef I2C_TARGET_MAP_SVH
`define I2C_TARGET_MAP_SVH

`define TGT_ADDR_W        7
`define TGT_DEFAULT_ADDR  7'h2E
`define TGT_RD_BYTE       8'h5D
`define TGT_WR_BYTE       8'h5C
`define BYTE_LAST_BIT     3'h7

`define CORE_CLK_KHZ      25000
`define INIT_TIME_MS      30
`define INIT_CYCLES_DEF   (`INIT_TIME_MS * `CORE_CLK_KHZ)
`define INIT_CNT_W        20

`define SPEED_FAST        2'h0
`define SPEED_FAST_PLUS   2'h1
`define LOC_SET_ZERO      2'h0
`define LOC_SET_FIVE      2'h1
`define LOC_SET_ALL       2'h2
`define CAP_SPEED         `SPEED_FAST
`define CAP_LOC_SET       `LOC_SET_ZERO
`define CAP_GAP_NEED      4'h0
`define CAP_GAP_TIME      8'hFA
`define CAP_RESTART_GAP   8'hFA

`endif

// ---- core/i2c_target_pkg.sv ----
// Types shared by the I2C target front end.
// Constants live in the map header.
package i2c_target_pkg;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_DEC, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_DEC,
      ST_WR_HOLD, ST_WR_ACK, ST_RD_LOAD, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
   } tgt_state_e;

   // Gap need bits: [3] wr-after-rd, [2] wr-after-wr, [1] rd-after-wr, [0] rd-after-rd
   typedef struct packed {
      logic [1:0] speed;
      logic [1:0] loc_set;
      logic [3:0] gap_need;
      logic [7:0] gap_time;
      logic [7:0] restart_idle_gap;
   } cap_s;

   typedef struct packed {
      logic [7:0] data;
      logic       first;
   } wr_byte_s;

endpackage

// ---- core/pin_sync.sv ----
// Two-flop synchroniser for bus pins.
// Assumes inputs are asynchronous to core_clk_i.
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 2
) (
   input  wire logic         core_clk_i,
   input  wire logic         arst_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta;

   // Idle bus level is high, so reset to high
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta   <= '1;
         sync_o <= '1;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule

// ---- core/i2c_target.sv ----
// I2C target front end: address match, byte transfer, stretching, interrupt pin.
// Assumes external pull-ups; pins resolved from the enables by the bench.
`timescale 1ns/1ns
`include "i2c_target_map.svh"
module i2c_target #(
   parameter int unsigned INIT_CYCLES = `INIT_CYCLES_DEF
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       arst_n_i,
   input  wire logic                       scl_i,
   output logic                            scl_o,
   output logic                            scl_oe_o,
   input  wire logic                       sda_i,
   output logic                            sda_o,
   output logic                            sda_oe_o,
   input  wire logic                       addr_load_i,
   input  wire logic [`TGT_ADDR_W-1:0]     addr_new_i,
   input  wire logic                       busy_i,
   input  wire logic                       wr_ready_i,
   input  wire logic                       wr_full_i,
   output i2c_target_pkg::wr_byte_s        wr_byte_o,
   output logic                            wr_valid_o,
   output logic                            wr_commit_o,
   output logic                            wr_abort_o,
   output logic                            rd_req_o,
   input  wire logic                       rd_valid_i,
   input  wire logic [7:0]                 rd_data_i,
   input  wire logic                       resp_ready_i,
   input  wire logic [7:0]                 event_i,
   input  wire logic [7:0]                 event_en_i,
   output logic                            response_ready_irq_n_o,
   output logic                            ready_o,
   output logic [`TGT_ADDR_W-1:0]          own_addr_o,
   output i2c_target_pkg::cap_s            cap_o
);

   i2c_target_pkg::tgt_state_e state, next_state;
   logic [1:0]             pin_s;
   logic                   scl_d, sda_d;
   logic [2:0]             cnt, next_cnt;
   logic [7:0]             sh, next_sh;
   logic                   next_sda_oe, next_scl_oe;
   logic                   next_wr_valid, next_commit, next_abort, next_rd_req;
   logic                   wr_open, next_wr_open;
   logic                   first, next_first;
   logic                   mack, next_mack;
   logic [`INIT_CNT_W-1:0] init_cnt;

   pin_sync #(.W(2)) u_sync (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .async_i    ({scl_i, sda_i}),
      .sync_o     (pin_s)
   );

   wire scl_s     = pin_s[1];
   wire sda_s     = pin_s[0];
   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
   wire byte_end  = scl_rise & (cnt == `BYTE_LAST_BIT);
   wire [7:0] byte_in = {sh[6:0], sda_s};
   wire addr_hit  = (sh[7:1] == own_addr_o);
   wire dir_read  = sh[0];
   wire addr_ok   = addr_hit & ready_o & ~busy_i;
   wire init_done = (init_cnt == INIT_CYCLES[`INIT_CNT_W-1:0]);
   wire evt_irq   = |(event_i & event_en_i);

   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_sh       = sh;
      next_sda_oe   = sda_oe_o;
      next_scl_oe   = scl_oe_o;
      next_wr_valid = 1'b0;
      next_commit   = 1'b0;
      next_abort    = 1'b0;
      next_rd_req   = 1'b0;
      next_wr_open  = wr_open;
      next_first    = first;
      next_mack     = mack;
      if (start_det || stop_det) begin
         next_commit  = wr_open;
         next_wr_open = 1'b0;
         next_sda_oe  = 1'b0;
         next_scl_oe  = 1'b0;
         next_cnt     = 3'h0;
         next_state   = start_det ? i2c_target_pkg::ST_ADDR : i2c_target_pkg::ST_IDLE;
      end else begin
         unique case (state)
            i2c_target_pkg::ST_IDLE, i2c_target_pkg::ST_IGNORE: begin
               next_sda_oe = 1'b0;
            end
            i2c_target_pkg::ST_ADDR, i2c_target_pkg::ST_WR_BYTE: begin
               if (scl_rise) begin
                  next_sh  = byte_in;
                  next_cnt = cnt + 3'h1;
               end
               if (byte_end) begin
                  next_state = (state == i2c_target_pkg::ST_ADDR) ?
                               i2c_target_pkg::ST_ADDR_DEC : i2c_target_pkg::ST_WR_DEC;
               end
            end
            i2c_target_pkg::ST_ADDR_DEC: begin
               if (scl_fall) begin
                  next_sda_oe = addr_ok;
                  next_state  = addr_ok ? i2c_target_pkg::ST_ADDR_ACK :
                                          i2c_target_pkg::ST_IGNORE;
               end
            end
            i2c_target_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  next_sda_oe  = 1'b0;
                  next_first   = 1'b1;
                  next_wr_open = ~dir_read;
                  next_scl_oe  = dir_read;
                  next_rd_req  = dir_read;
                  next_state   = dir_read ? i2c_target_pkg::ST_RD_LOAD :
                                            i2c_target_pkg::ST_WR_BYTE;
               end
            end
            i2c_target_pkg::ST_WR_DEC: begin
               if (scl_fall) begin
                  next_scl_oe = 1'b1;
                  next_state  = i2c_target_pkg::ST_WR_HOLD;
               end
            end
            i2c_target_pkg::ST_WR_HOLD: begin
               if (wr_full_i) begin
                  next_abort   = 1'b1;
                  next_wr_open = 1'b0;
                  next_scl_oe  = 1'b0;
                  next_state   = i2c_target_pkg::ST_IGNORE;
               end else if (wr_ready_i) begin
                  next_wr_valid = 1'b1;
                  next_sda_oe   = 1'b1;
                  next_scl_oe   = 1'b0;
                  next_state    = i2c_target_pkg::ST_WR_ACK;
               end
            end
            i2c_target_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  next_first  = 1'b0;
                  next_cnt    = 3'h0;
                  next_state  = i2c_target_pkg::ST_WR_BYTE;
               end
            end
            i2c_target_pkg::ST_RD_LOAD: begin
               if (rd_valid_i) begin
                  next_sh     = rd_data_i;
                  next_sda_oe = ~rd_data_i[7];
                  next_scl_oe = 1'b0;
                  next_cnt    = 3'h0;
                  next_state  = i2c_target_pkg::ST_RD_BYTE;
               end
            end
            i2c_target_pkg::ST_RD_BYTE: begin
               if (scl_fall) begin
                  next_sh     = {sh[6:0], 1'b1};
                  next_cnt    = cnt + 3'h1;
                  next_sda_oe = (cnt == `BYTE_LAST_BIT) ? 1'b0 : ~sh[6];
                  if (cnt == `BYTE_LAST_BIT) begin
                     next_state = i2c_target_pkg::ST_RD_ACK;
                  end
               end
            end
            i2c_target_pkg::ST_RD_ACK: begin
               if (scl_rise) begin
                  next_mack = ~sda_s;
               end
               if (scl_fall) begin
                  next_scl_oe = mack;
                  next_rd_req = mack;
                  next_state  = mack ? i2c_target_pkg::ST_RD_LOAD :
                                       i2c_target_pkg::ST_IGNORE;
               end
            end
            default: next_state = i2c_target_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state    <= i2c_target_pkg::ST_IDLE;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         cnt      <= 3'h0;
         sh       <= 8'h00;
         wr_open  <= 1'b0;
         first    <= 1'b0;
         mack     <= 1'b0;
         sda_oe_o <= 1'b0;
         scl_oe_o <= 1'b0;
      end else begin
         state    <= next_state;
         scl_d    <= scl_s;
         sda_d    <= sda_s;
         cnt      <= next_cnt;
         sh       <= next_sh;
         wr_open  <= next_wr_open;
         first    <= next_first;
         mack     <= next_mack;
         sda_oe_o <= next_sda_oe;
         scl_oe_o <= next_scl_oe;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_valid_o  <= 1'b0;
         wr_byte_o   <= '0;
         wr_commit_o <= 1'b0;
         wr_abort_o  <= 1'b0;
         rd_req_o    <= 1'b0;
      end else begin
         wr_valid_o  <= next_wr_valid;
         wr_byte_o   <= next_wr_valid ? i2c_target_pkg::wr_byte_s'{data: sh, first: first} :
                                        wr_byte_o;
         wr_commit_o <= next_commit;
         wr_abort_o  <= next_abort;
         rd_req_o    <= next_rd_req;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_cnt <= '0;
         ready_o  <= 1'b0;
      end else begin
         init_cnt <= init_done ? init_cnt : init_cnt + `INIT_CNT_W'(1);
         ready_o  <= init_done;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         own_addr_o <= `TGT_DEFAULT_ADDR;
      end else if (addr_load_i) begin
         own_addr_o <= addr_new_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         response_ready_irq_n_o <= 1'b1;
      end else begin
         response_ready_irq_n_o <= ~(resp_ready_i | evt_irq);
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cap_o <= '{speed: `CAP_SPEED, loc_set: `CAP_LOC_SET, gap_need: `CAP_GAP_NEED,
                    gap_time: `CAP_GAP_TIME, restart_idle_gap: `CAP_RESTART_GAP};
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         cap_o <= cap_o;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   addr_ack_own_a: assert property (
      state == i2c_target_pkg::ST_ADDR_DEC && scl_fall && !addr_hit |=> !sda_oe_o)
      else $error("Foreign address acknowledged");
   addr_nack_busy_a: assert property (
      state == i2c_target_pkg::ST_ADDR_DEC && scl_fall && busy_i
      |=> state == i2c_target_pkg::ST_IGNORE && !sda_oe_o)
      else $error("Busy target acknowledged address");
   ignore_quiet_a: assert property (
      state == i2c_target_pkg::ST_IGNORE |=> !sda_oe_o && !scl_oe_o && !wr_valid_o)
      else $error("Ignored transfer drives the bus");
   init_ready_a: assert property (
      $rose(ready_o) |-> $past(init_cnt) == INIT_CYCLES[`INIT_CNT_W-1:0])
      else $error("Ready at wrong cycle");
   stretch_only_a: assert property (
      scl_oe_o |-> state inside {i2c_target_pkg::ST_WR_HOLD, i2c_target_pkg::ST_RD_LOAD}
                   || $past(start_det || stop_det))
      else $error("SCL held outside stretch");
   full_abort_a: assert property (
      state == i2c_target_pkg::ST_WR_HOLD && wr_full_i |-> ##1 wr_abort_o && !wr_valid_o
                                                           ##1 !sda_oe_o)
      else $error("Full write not refused");
   abort_no_commit_a: assert property (
      wr_abort_o |-> !wr_open ##1 !wr_commit_o)
      else $error("Aborted write later committed");
   restart_commit_a: assert property (
      start_det && wr_open |=> wr_commit_o ##1 !wr_commit_o)
      else $error("Repeated start lost the write");
   irq_follow_a: assert property (
      resp_ready_i |=> !response_ready_irq_n_o)
      else $error("Interrupt pin not low");
   read_request_a: assert property (
      rd_req_o |-> state == i2c_target_pkg::ST_RD_LOAD && scl_oe_o)
      else $error("Read request without stretch");

   write_seen_c: cover property (wr_valid_o ##[1:400] wr_commit_o);
   read_seen_c: cover property (rd_req_o ##[1:800] state == i2c_target_pkg::ST_RD_ACK);
   nack_seen_c: cover property (wr_abort_o);
   restart_seen_c: cover property (start_det && wr_open);

endmodule

// ---- testbench/i2c_master_model.sv ----
// Host bus master model: open-drain SCL and SDA, bit and byte tasks.
// Assumes the bench resolves wire levels with pull-ups.
`timescale 1ns/1ns
module i2c_master_model #(
   parameter int HALF = 4,
   parameter int GAP  = 6250
) (
   input  wire logic core_clk_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_oe_o,
   output logic      sda_oe_o
);
   int stuck = 0;
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic free_scl();
      int k;
      k = 0;
      scl_oe_o = 1'b0;
      tick(1);
      while (scl_i !== 1'b1 && k < 2000) begin
         tick(1);
         k++;
      end
      if (k >= 2000) stuck++;
   endtask
   task automatic bit_xfer(input logic b, output logic r);
      sda_oe_o = ~b;
      tick(HALF);
      free_scl();
      tick(HALF);
      r = sda_i;
      scl_oe_o = 1'b1;
      tick(1);
   endtask
   task automatic start(input logic sr);
      if (sr) tick(GAP);
      sda_oe_o = 1'b0;
      tick(HALF);
      free_scl();
      tick(HALF);
      sda_oe_o = 1'b1;
      tick(HALF);
      scl_oe_o = 1'b1;
      tick(1);
   endtask
   task automatic stop();
      sda_oe_o = 1'b1;
      tick(HALF);
      free_scl();
      tick(HALF);
      sda_oe_o = 1'b0;
      tick(GAP);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, r);
         d[i] = r;
      end
      bit_xfer(~ack, r);
   endtask
endmodule

// ---- testbench/secure_module_i2c_target_tb_top.sv ----
// Bench for the I2C target front end: master model, read responder, checks.
// Assumes open-drain pins with pull-ups; shortened init delay.
`timescale 1ns/1ns
`include "i2c_target_map.svh"
module secure_module_i2c_target_tb_top;
   localparam int INIT = 200;
   logic                     core_clk   = 1'b0;
   logic                     arst_n     = 1'b0;
   logic                     addr_load  = 1'b0;
   logic                     busy       = 1'b0;
   logic                     wr_ready   = 1'b1;
   logic                     wr_full    = 1'b0;
   logic                     rd_valid   = 1'b0;
   logic                     resp_ready = 1'b0;
   logic [6:0]               addr_new   = 7'h00;
   logic [7:0]               rd_data    = 8'hC3;
   logic [7:0]               event_lv   = 8'h00;
   logic [7:0]               event_en   = 8'h00;
   logic                     scl_w, sda_w, m_scl_oe, m_sda_oe, scl_o, scl_oe, sda_o, sda_oe;
   logic                     wr_valid, wr_commit, wr_abort, rd_req, irq_n, ready;
   logic [6:0]               own_addr;
   logic [2:0]               ak;
   logic [15:0]              rx;
   i2c_target_pkg::wr_byte_s wr_byte, last;
   i2c_target_pkg::cap_s     cap;
   int bad_count = 0, compares = 0, n_valid, n_commit, n_abort, n_oe, n_str, ready_cyc = 0;
   assign scl_w = ~m_scl_oe & ~(scl_oe & ~scl_o);
   assign sda_w = ~m_sda_oe & ~(sda_oe & ~sda_o);
   initial forever #20 core_clk = ~core_clk;
   i2c_target #(.INIT_CYCLES(INIT)) i2c_target_i (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .addr_load_i(addr_load), .addr_new_i(addr_new), .busy_i(busy), .wr_ready_i(wr_ready),
      .wr_full_i(wr_full), .wr_byte_o(wr_byte), .wr_valid_o(wr_valid),
      .wr_commit_o(wr_commit), .wr_abort_o(wr_abort), .rd_req_o(rd_req),
      .rd_valid_i(rd_valid), .rd_data_i(rd_data), .resp_ready_i(resp_ready),
      .event_i(event_lv), .event_en_i(event_en), .response_ready_irq_n_o(irq_n),
      .ready_o(ready), .own_addr_o(own_addr), .cap_o(cap));
   i2c_master_model i2c_master_model_i (
      .core_clk_i(core_clk), .scl_i(scl_w), .sda_i(sda_w),
      .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Sampled mid-cycle so one-cycle pulses are settled
   always @(negedge core_clk) begin
      if (wr_valid === 1'b1) n_valid++;
      if (wr_valid === 1'b1) last = wr_byte;
      if (wr_commit === 1'b1) n_commit++;
      if (wr_abort === 1'b1) n_abort++;
      if (sda_oe === 1'b1) n_oe++;
      if (scl_oe === 1'b1) n_str++;
      if (arst_n === 1'b1 && ready !== 1'b1) ready_cyc++;
   end
   // Late read data forces the target to stretch
   always @(negedge core_clk) begin
      if (rd_req === 1'b1) begin
         tick(10);
         rd_data = ~rd_data;
         rd_valid = 1'b1;
         tick(1);
         rd_valid = 1'b0;
      end
   end
   task automatic end_sim();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic clr();
      n_valid = 0; n_commit = 0; n_abort = 0; n_oe = 0; n_str = 0;
   endtask
   function automatic logic [23:0] cnt();
      return 24'(n_valid * 256 + n_commit * 16 + n_abort);
   endfunction
   task automatic wr_xfer(input logic [7:0] a, input logic [7:0] d);
      clr();
      i2c_master_model_i.start(1'b0);
      i2c_master_model_i.send(a, ak[1]);
      i2c_master_model_i.send(d, ak[0]);
      i2c_master_model_i.stop();
   endtask
   task automatic load_addr(input logic [6:0] a);
      addr_new = a;
      addr_load = 1'b1;
      tick(1);
      addr_load = 1'b0;
      tick(2);
   endtask
   task automatic wait_stretch();
      int k;
      k = 0;
      while (scl_oe !== 1'b1 && k < 4000) begin
         tick(1);
         k++;
      end
      if (k >= 4000) begin
         bad_count++;
         end_sim();
      end
   endtask
   initial begin
      #4000000;
      bad_count++;
      end_sim();
   end
   initial begin
      clr();
      tick(20);
      chk(24'({irq_n, ready, own_addr}), 24'h12E);
      arst_n = 1'b1;
      wr_xfer(8'h5C, 8'h11);
      chk(24'({ak[1:0], n_oe != 0}), 24'h0);
      chk(24'(ready_cyc >= INIT && ready_cyc <= INIT + 2), 24'h1);
      chk(24'(cap), {`SPEED_FAST, `LOC_SET_ZERO, 4'h0, 8'hFA, 8'hFA});
      wr_ready = 1'b0;
      fork
         wr_xfer(8'h5C, 8'hA5);
         begin
            wait_stretch();
            tick(20);
            wr_ready = 1'b1;
         end
      join
      chk(24'(ak[1:0]), 24'h3);
      chk(24'(last), 24'({8'hA5, 1'b1}));
      chk(24'(n_str >= 20), 24'h1);
      chk(cnt(), 24'h110);
      clr();
      i2c_master_model_i.start(1'b0);
      i2c_master_model_i.send(8'h5C, ak[2]);
      i2c_master_model_i.send(8'h10, ak[1]);
      i2c_master_model_i.start(1'b1);
      i2c_master_model_i.send(8'h5D, ak[0]);
      i2c_master_model_i.recv(1'b1, rx[15:8]);
      i2c_master_model_i.recv(1'b0, rx[7:0]);
      i2c_master_model_i.stop();
      chk(24'({ak, rx}), 24'h73CC3);
      chk(cnt(), 24'h110);
      chk(24'(last), 24'({8'h10, 1'b1}));
      wr_xfer(8'h50, 8'h00);
      chk(24'({ak[1:0], n_oe != 0}), 24'h0);
      chk(cnt(), 24'h0);
      load_addr(7'h21);
      chk(24'(own_addr), 24'h21);
      wr_xfer(8'h42, 8'h5A);
      chk(24'(ak[1:0]), 24'h3);
      wr_xfer(8'h5C, 8'h5A);
      chk(24'(ak[1:0]), 24'h0);
      load_addr(7'h2E);
      busy = 1'b1;
      wr_xfer(8'h5C, 8'h66);
      chk(24'(ak[1:0]), 24'h0);
      busy = 1'b0;
      wr_xfer(8'h5C, 8'h66);
      chk(24'(ak[1:0]), 24'h3);
      clr();
      i2c_master_model_i.start(1'b0);
      i2c_master_model_i.send(8'h5C, ak[2]);
      i2c_master_model_i.send(8'h77, ak[1]);
      wr_full = 1'b1;
      i2c_master_model_i.send(8'h88, ak[0]);
      i2c_master_model_i.stop();
      wr_full = 1'b0;
      chk(24'(ak), 24'h6);
      chk(cnt(), 24'h101);
      wr_xfer(8'h5C, 8'h77);
      chk(cnt(), 24'h110);
      resp_ready = 1'b1;
      tick(3);
      chk(24'(irq_n), 24'h0);
      resp_ready = 1'b0;
      event_lv = 8'h04;
      tick(3);
      chk(24'(irq_n), 24'h1);
      event_en = 8'h04;
      tick(3);
      chk(24'(irq_n), 24'h0);
      chk(24'(i2c_master_model_i.stuck), 24'h0);
      end_sim();
   end
endmodule
